// ---- logic/acs_master.sv ----
// Master for an ASCII command protocol over an 8N1 serial line, plus its transmit FIFO.
// Assumes a single ref_clk domain; rxd arrives asynchronously from the slave.
// Functional notes
// - Characters are 8 data bits, 1 stop bit, no parity, no handshake.
// - Commands go out gap-free; slave gaps over 100 ms abort the reply.
// - No new command starts until the full reply including CR arrived; the master also accepts one after a timeout.
// - Commands start with the master prefix, replies with the slave prefix.
// - Byte one is the start character, bytes three and four the address.
// - Byte five is the qualifier; the reply must echo it.
// - Two hex length characters count start through data bytes.
// - Checksum is the modulo-256 sum of all bytes before it.
// - Checksum goes as two hex characters, high first, then CR.
// - Temperatures are signed 16-bit values, one count per 0.01 K.
// - Each value is four hex characters, most significant nibble first.
`timescale 1ns/10ps
`include "acs_regs.svh"

module acs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp;
  logic [AW-1:0]    rp;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wp    <= '0;
      rp    <= '0;
      count <= '0;
    end else begin
      if (push) wp <= (wp == AW'(DEPTH-1)) ? '0 : wp + 1'b1;
      if (pop)  rp <= (rp == AW'(DEPTH-1)) ? '0 : rp + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : acs_fifo

module acs_master
  import acs_pkg::*;
#(
  parameter int GAP_CYC  = `ACS_GAP_MS * `ACS_CLK_KHZ,
  parameter int RESP_CYC = `ACS_RSP_MS * `ACS_CLK_KHZ,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Configuration
  input  wire logic [15:0] baud_div,
  // Command request
  input  wire logic        cmd_valid,
  input  wire logic        cmd_kind,
  output logic             cmd_ready,
  // Result
  output logic             done,
  output logic [1:0]       result,
  output logic             id_valid,
  output logic [7:0]       id_char,
  output logic [15:0]      lim_set_lo,
  output logic [15:0]      lim_set_hi,
  output logic [15:0]      lim_work_lo,
  output logic [15:0]      lim_work_hi,
  // Serial pins
  output logic             txd,
  input  wire logic        rxd
);

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction : hex_char

  // Upper-case only; bit 4 flags a valid digit
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) hex_val = {1'b1, c[3:0]};
    else if (c >= 8'h41 && c <= 8'h46) hex_val = {1'b1, c[3:0] + 4'h9};
    else hex_val = 5'h00;
  endfunction : hex_val

  acs_state_t  state;
  acs_cmd_t    kind;
  logic [7:0]  tx_idx;
  logic [7:0]  tx_sum;
  logic [7:0]  tx_len;
  logic [7:0]  tx_byte;
  logic        all_pushed;
  logic        f_in_valid;
  logic        f_in_ready;
  logic        f_out_valid;
  logic [7:0]  f_out_data;
  logic        f_out_ready;
  logic        tx_busy;
  logic [9:0]  tx_sh;
  logic [15:0] tx_cnt;
  logic [3:0]  tx_bit;
  logic        rxd_s1;
  logic        rxd_s2;
  logic        rx_busy;
  logic [15:0] rx_cnt;
  logic [3:0]  rx_bit;
  logic [7:0]  rx_sh;
  logic        rx_stb;
  logic [7:0]  rx_byte;
  logic        rx_ferr;
  logic [7:0]  pos;
  logic [7:0]  rsp_len;
  logic [7:0]  rsp_sum;
  logic [7:0]  got_sum;
  logic        bad;
  logic        got_any;
  logic [31:0] tmr;
  logic [63:0] lim_sh;
  logic [4:0]  hv;
  logic [7:0]  exp_len;
  logic [7:0]  qual;

  assign tx_len  = (kind == ACS_CMD_LIMIT) ? `ACS_CMD_LEN_L : `ACS_CMD_LEN_V;
  assign exp_len = (kind == ACS_CMD_LIMIT) ? `ACS_RSP_LEN_L : `ACS_RSP_LEN_V;
  assign qual    = (kind == ACS_CMD_LIMIT) ? `ACS_CH_QUAL_L : `ACS_CH_QUAL_V;
  assign hv      = hex_val(rx_byte);

  // Command frame builder; fill bytes pad the limit query data field
  always_comb begin
    case (tx_idx)
      8'h00:   tx_byte = `ACS_CH_START;
      8'h01:   tx_byte = `ACS_CH_MASTER;
      8'h02:   tx_byte = `ACS_CH_ADDR0;
      8'h03:   tx_byte = `ACS_CH_ADDR1;
      8'h04:   tx_byte = qual;
      8'h05:   tx_byte = hex_char(tx_len[7:4]);
      8'h06:   tx_byte = hex_char(tx_len[3:0]);
      default: begin
        if (tx_idx < tx_len) tx_byte = `ACS_CH_FILL;
        else if (tx_idx == tx_len) tx_byte = hex_char(tx_sum[7:4]);
        else if (tx_idx == tx_len + 8'h01) tx_byte = hex_char(tx_sum[3:0]);
        else tx_byte = `ACS_CH_CR;
      end
    endcase
  end

  assign f_in_valid  = (state == ACS_ST_SEND) && !all_pushed;
  assign f_out_ready = !tx_busy;

  // Buffer decouples frame building from the slow line; full stalls the builder
  acs_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (f_in_valid),
    .in_data   (tx_byte),
    .in_ready  (f_in_ready),
    .out_valid (f_out_valid),
    .out_data  (f_out_data),
    .out_ready (f_out_ready)
  );

  // Serial transmitter, 8N1
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_busy <= 1'b0;
      tx_sh   <= 10'h3ff;
      tx_cnt  <= 16'h0000;
      tx_bit  <= 4'h0;
      txd     <= 1'b1;
    end else if (!tx_busy) begin
      if (f_out_valid) begin
        tx_busy <= 1'b1;
        tx_sh   <= {1'b1, f_out_data, 1'b0};
        tx_cnt  <= baud_div - 16'h0001;
        tx_bit  <= 4'h0;
        txd     <= 1'b0;
      end
    end else if (tx_cnt == 16'h0000) begin
      tx_cnt <= baud_div - 16'h0001;
      if (tx_bit == 4'h9) begin
        tx_busy <= 1'b0;
      end else begin
        tx_sh  <= {1'b1, tx_sh[9:1]};
        txd    <= tx_sh[1];
        tx_bit <= tx_bit + 4'h1;
      end
    end else begin
      tx_cnt <= tx_cnt - 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
    end else begin
      rxd_s1 <= rxd;
      rxd_s2 <= rxd_s1;
    end
  end

  // Serial receiver, samples mid-bit
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rx_busy <= 1'b0;
      rx_cnt  <= 16'h0000;
      rx_bit  <= 4'h0;
      rx_sh   <= 8'h00;
      rx_stb  <= 1'b0;
      rx_byte <= 8'h00;
      rx_ferr <= 1'b0;
    end else begin
      rx_stb <= 1'b0;
      if (!rx_busy) begin
        if (!rxd_s2) begin
          rx_busy <= 1'b1;
          rx_cnt  <= {1'b0, baud_div[15:1]};
          rx_bit  <= 4'h0;
        end
      end else if (rx_cnt == 16'h0000) begin
        rx_cnt <= baud_div - 16'h0001;
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0) begin
          if (rxd_s2) rx_busy <= 1'b0;
        end else if (rx_bit < 4'h9) begin
          rx_sh <= {rxd_s2, rx_sh[7:1]};
        end else begin
          rx_stb  <= 1'b1;
          rx_byte <= rx_sh;
          rx_ferr <= !rxd_s2;
          rx_busy <= 1'b0;
        end
      end else begin
        rx_cnt <= rx_cnt - 16'h0001;
      end
    end
  end

  // Request sequencing; one command in flight at a time
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state      <= ACS_ST_IDLE;
      kind       <= ACS_CMD_VERIFY;
      tx_idx     <= 8'h00;
      tx_sum     <= 8'h00;
      all_pushed <= 1'b0;
      cmd_ready  <= 1'b1;
    end else begin
      case (state)
        ACS_ST_IDLE: begin
          if (cmd_valid) begin
            kind       <= acs_cmd_t'(cmd_kind);
            tx_idx     <= 8'h00;
            tx_sum     <= 8'h00;
            all_pushed <= 1'b0;
            cmd_ready  <= 1'b0;
            state      <= ACS_ST_SEND;
          end
        end
        ACS_ST_SEND: begin
          if (f_in_valid && f_in_ready) begin
            if (tx_idx < tx_len) tx_sum <= tx_sum + tx_byte;
            if (tx_idx == tx_len + 8'h02) all_pushed <= 1'b1;
            tx_idx <= tx_idx + 8'h01;
          end
          // Reply timing counts from the end of the last stop bit
          if (all_pushed && !f_out_valid && !tx_busy) state <= ACS_ST_WAIT;
        end
        ACS_ST_WAIT: begin
          if (done) state <= ACS_ST_DONE;
        end
        ACS_ST_DONE: begin
          cmd_ready <= 1'b1;
          state     <= ACS_ST_IDLE;
        end
        default: state <= ACS_ST_IDLE;
      endcase
    end
  end

  // Reply parser; bytes outside a wait are dropped
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pos      <= 8'h00;
      rsp_len  <= 8'h00;
      rsp_sum  <= 8'h00;
      got_sum  <= 8'h00;
      bad      <= 1'b0;
      got_any  <= 1'b0;
      tmr      <= 32'h0;
      lim_sh   <= 64'h0;
      done     <= 1'b0;
      result   <= 2'h0;
      id_valid <= 1'b0;
      id_char  <= 8'h00;
    end else begin
      done     <= 1'b0;
      id_valid <= 1'b0;
      if (state != ACS_ST_WAIT || done) begin
        pos     <= 8'h00;
        rsp_sum <= 8'h00;
        bad     <= 1'b0;
        got_any <= 1'b0;
        tmr     <= 32'h0;
      end else if (rx_stb) begin
        got_any <= 1'b1;
        tmr     <= 32'h0;
        pos     <= pos + 8'h01;
        if (pos < rsp_len || pos < `ACS_HDR_LEN) rsp_sum <= rsp_sum + rx_byte;
        if (rx_ferr) bad <= 1'b1;
        case (pos)
          8'h00: if (rx_byte != `ACS_CH_START) bad <= 1'b1;
          8'h01: if (rx_byte != `ACS_CH_SLAVE) bad <= 1'b1;
          8'h02: if (rx_byte != `ACS_CH_ADDR0) bad <= 1'b1;
          8'h03: if (rx_byte != `ACS_CH_ADDR1) bad <= 1'b1;
          8'h04: if (rx_byte != qual) bad <= 1'b1;
          8'h05: begin
            rsp_len[7:4] <= hv[3:0];
            if (!hv[4]) bad <= 1'b1;
          end
          8'h06: begin
            rsp_len[3:0] <= hv[3:0];
            if (!hv[4] || {rsp_len[7:4], hv[3:0]} != exp_len) bad <= 1'b1;
          end
          default: begin
            if (rx_byte == `ACS_CH_CR && (bad || pos >= rsp_len + 8'h02)) begin
              done <= 1'b1;
              if (bad || pos != rsp_len + 8'h02 || got_sum != rsp_sum) begin
                result <= ACS_RES_BAD;
              end else if (kind == ACS_CMD_LIMIT &&
                           ($signed(lim_sh[63:48]) < $signed(lim_sh[31:16]) ||
                            $signed(lim_sh[47:32]) > $signed(lim_sh[15:0]))) begin
                result <= ACS_RES_LIMITS;
              end else begin
                result <= ACS_RES_OK;
              end
              if (kind == ACS_CMD_LIMIT) begin
                lim_set_lo  <= lim_sh[63:48];
                lim_set_hi  <= lim_sh[47:32];
                lim_work_lo <= lim_sh[31:16];
                lim_work_hi <= lim_sh[15:0];
              end
            end else if (pos < rsp_len) begin
              if (kind == ACS_CMD_LIMIT) begin
                lim_sh <= {lim_sh[59:0], hv[3:0]};
                if (!hv[4]) bad <= 1'b1;
              end else begin
                id_valid <= 1'b1;
                id_char  <= rx_byte;
              end
            end else if (pos < rsp_len + 8'h02) begin
              got_sum <= {got_sum[3:0], hv[3:0]};
              if (!hv[4]) bad <= 1'b1;
            end else begin
              bad <= 1'b1;
            end
          end
        endcase
      end else begin
        // Silence limit: first byte waits for the reply time, later ones for the gap
        tmr <= tmr + 32'h1;
        if (tmr >= (got_any ? 32'(GAP_CYC) : 32'(RESP_CYC))) begin
          done   <= 1'b1;
          result <= ACS_RES_TIMEOUT;
        end
      end
    end
  end

endmodule : acs_master

// ---- logic/acs_regs.svh ----
// Constants for the ASCII serial command master: frame characters, lengths, timing.
// Assumes a 100 MHz ref_clk; times are given in ms and converted in the master.
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

`define ACS_CH_START    8'h5b
`define ACS_CH_MASTER   8'h4d
`define ACS_CH_SLAVE    8'h53
`define ACS_CH_ADDR0    8'h30
`define ACS_CH_ADDR1    8'h31
`define ACS_CH_QUAL_V   8'h56
`define ACS_CH_QUAL_L   8'h4c
`define ACS_CH_FILL     8'h2a
`define ACS_CH_CR       8'h0d

`define ACS_HDR_LEN     8'h07
`define ACS_CMD_LEN_V   8'h07
`define ACS_CMD_LEN_L   8'h0f
`define ACS_RSP_LEN_V   8'h14
`define ACS_RSP_LEN_L   8'h17

`define ACS_CLK_KHZ     100000
`define ACS_GAP_MS      100
`define ACS_RSP_MS      300
`define ACS_DIV_9600    16'h28b1
`define ACS_DIV_115200  16'h0364

`endif

// ---- logic/acs_pkg.sv ----
// Types shared by the ASCII serial command master.
// Assumes acs_regs.svh carries the numeric constants.
package acs_pkg;

  typedef enum logic [3:0] {
    ACS_ST_IDLE = 4'h1,
    ACS_ST_SEND = 4'h2,
    ACS_ST_WAIT = 4'h4,
    ACS_ST_DONE = 4'h8
  } acs_state_t;

  typedef enum logic {
    ACS_CMD_VERIFY = 1'b0,
    ACS_CMD_LIMIT  = 1'b1
  } acs_cmd_t;

  typedef enum logic [1:0] {
    ACS_RES_OK      = 2'h0,
    ACS_RES_BAD     = 2'h1,
    ACS_RES_TIMEOUT = 2'h2,
    ACS_RES_LIMITS  = 2'h3
  } acs_res_t;

endpackage : acs_pkg

// ---- sim/acs_master_sva.sv ----
// Port checks for the serial command master.
// Assumes one ref_clk domain with synchronous active-low rst_n.
`timescale 1ns/10ps

module acs_master_sva (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_n,
  // Command and result
  input wire logic       cmd_valid,
  input wire logic       cmd_ready,
  input wire logic       done,
  input wire logic [1:0] result,
  input wire logic       id_valid,
  // Serial out
  input wire logic       txd
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_take;
    cmd_valid && cmd_ready;
  endsequence
  sequence s_release;
    !cmd_ready ##1 cmd_ready;
  endsequence

  a_take_busy: assert property (s_take |=> !cmd_ready)
    else $error("ready high after take");
  a_start_bit: assert property (s_take |-> ##[1:3] !txd)
    else $error("no start bit after take");
  a_quiet_idle: assert property (cmd_ready |-> txd)
    else $error("txd active while idle");
  a_bit_width: assert property ($fell(txd) |-> (!txd) [*8])
    else $error("low bit too short");
  a_done_pulse: assert property (done |=> !done)
    else $error("done too long");
  a_done_release: assert property (done |=> s_release)
    else $error("ready not back after done");
  a_result_held: assert property ($changed(result) |-> done)
    else $error("result moved without done");
  a_id_busy: assert property (id_valid |-> !cmd_ready && !done)
    else $error("id char outside a reply");
  a_no_early_done: assert property (s_take |=> (!done) [*8])
    else $error("done too soon");
endmodule : acs_master_sva

// ---- sim/acs_slave_model.sv ----
// Behavioural slave: parses commands on txd, answers on rxd.
// Assumes 8N1 at baud_div clocks per bit; the bench picks the misbehaviour.
`timescale 1ns/10ps

module acs_slave_model #(
  parameter logic [103:0] ID_TEXT = "Bath Ctl Unit" // Arbitrary identification text
) (
  // Clock
  input  wire logic        ref_clk,
  // Serial pins
  input  wire logic        txd,
  output logic             rxd,
  // Behaviour: mode 0 good, 1 bad checksum, 2 reply cut short, 3 wrong qualifier
  input  wire logic [15:0] baud_div,
  input  wire logic [1:0]  mode,
  input  wire logic [15:0] lag,
  input  wire logic [63:0] lims
);
  function automatic logic [7:0] hx(input logic [3:0] v);
    return (v < 4'ha) ? 8'h30 + {4'h0, v} : 8'h37 + {4'h0, v};
  endfunction : hx

  task automatic get_byte(output logic [7:0] b);
    @(negedge txd);
    repeat (baud_div / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (baud_div) @(posedge ref_clk);
      b[i] = txd;
    end
    repeat (baud_div) @(posedge ref_clk);
  endtask : get_byte

  task automatic put_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (baud_div) @(posedge ref_clk);
    end
  endtask : put_byte

  initial begin
    logic [7:0] b;
    logic [7:0] n;
    logic [7:0] s;
    logic [7:0] q[$];
    logic [7:0] r[$];
    rxd = 1'b1;
    forever begin
      q.delete();
      do begin
        get_byte(b);
        q.push_back(b);
      end while (b != 8'h0d);
      n = 8'(q.size() - 3);
      s = 8'h00;
      for (int i = 0; i < q.size() - 3; i++) s = s + q[i];
      // Malformed commands get no answer at all
      if (q.size() < 10 || {q[0], q[1], q[2], q[3]} != 32'h5b4d3031
          || !(q[4] inside {8'h56, 8'h4c}) || {q[5], q[6], q[n], q[n + 1]}
          != {hx(n[7:4]), hx(n[3:0]), hx(s[7:4]), hx(s[3:0])})
        continue;
      n = (q[4] == 8'h56) ? 8'h14 : 8'h17;
      r = {8'h5b, 8'h53, 8'h30, 8'h31, q[4], hx(n[7:4]), hx(n[3:0])};
      // Swapping V and L keeps the checksum honest so only the echo is wrong
      if (mode == 2'h3) r[4] = r[4] ^ 8'h1a;
      for (int i = 0; i < 13 && n == 8'h14; i++) r.push_back(ID_TEXT[8 * (12 - i) +: 8]);
      for (int i = 0; i < 16 && n == 8'h17; i++) r.push_back(hx(lims[63 - 4 * i -: 4]));
      s = 8'h00;
      foreach (r[i]) s = s + r[i];
      s = s + {7'h0, mode == 2'h1};
      r.push_back(hx(s[7:4]));
      r.push_back(hx(s[3:0]));
      r.push_back(8'h0d);
      repeat (lag) @(posedge ref_clk);
      foreach (r[i]) begin
        if (mode == 2'h2 && i == 6)
          break;
        put_byte(r[i]);
      end
    end
  end
endmodule : acs_slave_model

// ---- sim/test_acs_master.sv ----
// Self-checking bench: the serial command master against a behavioural slave.
// Assumes acs_slave_model and acs_master_sva are compiled before this file.
`timescale 1ns/10ps

module test_acs_master
  import acs_pkg::*;
;
  localparam logic [103:0] ID_TEXT = "Bath Ctl Unit"; // Arbitrary identification text

  logic        ref_clk   = 1'b0;
  logic        rst_n     = 1'b0;
  logic        cmd_valid = 1'b0;
  logic        cmd_kind  = 1'b0;
  logic [15:0] baud_div  = 16'h0010;
  logic [1:0]  mode      = 2'h0;
  logic [15:0] lag       = 16'h0000;
  logic [63:0] lims      = 64'h0;
  logic [31:0] rnd       = 32'h0001382b;
  logic        cmd_ready, done, id_valid, txd, rxd;
  logic [1:0]  result;
  logic [7:0]  id_char;
  logic [15:0] set_lo, set_hi, work_lo, work_hi;
  logic [7:0]  ids[$];
  int          err_total = 0;
  int          checked   = 0;

  always #5 ref_clk = ~ref_clk;

  acs_master #(.GAP_CYC(2000), .RESP_CYC(5000), .FIFO_DEPTH(8)) DUT (
    .ref_clk, .rst_n, .baud_div, .cmd_valid, .cmd_kind, .cmd_ready, .done, .result,
    .id_valid, .id_char, .lim_set_lo(set_lo), .lim_set_hi(set_hi), .lim_work_lo(work_lo),
    .lim_work_hi(work_hi), .txd, .rxd
  );

  acs_slave_model #(.ID_TEXT(ID_TEXT)) u_slave (
    .ref_clk, .txd, .rxd, .baud_div, .mode, .lag, .lims
  );

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  function automatic logic [1:0] exp_res(input logic k, input logic [1:0] m,
                                         input logic [15:0] lg, input logic [63:0] l);
    if (m == 2'h2 || lg > 16'd5000)
      return ACS_RES_TIMEOUT;
    if (m == 2'h1 || m == 2'h3)
      return ACS_RES_BAD;
    if (k && ($signed(l[63:48]) < $signed(l[31:16]) || $signed(l[47:32]) > $signed(l[15:0])))
      return ACS_RES_LIMITS;
    return ACS_RES_OK;
  endfunction : exp_res

  task automatic tally_and_finish;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic cmp_res(input string what, input logic [1:0] e, input logic [1:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask : cmp_res

  task automatic cmp_word(input string what, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask : cmp_word

  task automatic run(input logic k, input logic [1:0] m, input logic [15:0] lg,
                     input logic [63:0] l);
    int n;
    rnd = lfsr(rnd);
    cmd_kind  <= k;
    mode      <= m;
    lag       <= lg;
    lims      <= l;
    baud_div  <= 16'h0010 + {14'h0, rnd[1:0]};
    cmd_valid <= 1'b1;
    ids.delete();
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 10);
    cmp_res("cmd_ready", 2'h1, {1'b0, cmd_ready});
    cmd_valid <= 1'b0;
    while (done !== 1'b1 && n < 40000) begin
      @(posedge ref_clk);
      n++;
      if (id_valid === 1'b1)
        ids.push_back(id_char);
    end
    if (done !== 1'b1) begin
      err_total++;
      $display("BAD done exp 1 got %b", done);
      tally_and_finish();
    end
    cmp_res("result", exp_res(k, m, lg, l), result);
    if (m == 2'h0 && lg <= 16'd5000 && k) begin
      cmp_word("set_lo", l[63:48], set_lo);
      cmp_word("set_hi", l[47:32], set_hi);
      cmp_word("work_lo", l[31:16], work_lo);
      cmp_word("work_hi", l[15:0], work_hi);
    end
    if (m == 2'h0 && lg <= 16'd5000 && !k) begin
      cmp_word("id_count", 16'h000d, 16'(ids.size()));
      for (int i = 0; i < 13; i++)
        cmp_word("id_char", {8'h00, ID_TEXT[8 * (12 - i) +: 8]}, {8'h00, ids[i]});
    end
    // A late reply must finish before the next command goes out
    if (lg > 16'd5000)
      repeat (6000) @(posedge ref_clk);
  endtask : run

  initial begin
    logic [63:0] l;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    run(ACS_CMD_VERIFY, 2'h0, 16'd0, 64'h0);
    run(ACS_CMD_LIMIT, 2'h0, 16'd3000, 64'h80007fff80007fff);
    run(ACS_CMD_LIMIT, 2'h0, 16'd0, 64'h8000f448f4484e20);
    run(ACS_CMD_VERIFY, 2'h1, 16'd0, 64'h0);
    run(ACS_CMD_VERIFY, 2'h3, 16'd0, 64'h0);
    run(ACS_CMD_LIMIT, 2'h2, 16'd0, 64'h0);
    run(ACS_CMD_VERIFY, 2'h0, 16'd6000, 64'h0);
    repeat (4) begin
      rnd = lfsr(rnd);
      l[31:0] = rnd;
      rnd = lfsr(rnd);
      l[63:32] = rnd;
      run(rnd[3], {1'b0, rnd[4]}, {5'h0, rnd[15:5]}, l);
    end
    tally_and_finish();
  end
endmodule : test_acs_master

bind acs_master acs_master_sva u_sva (
  .ref_clk, .rst_n, .cmd_valid, .cmd_ready, .done, .result, .id_valid, .txd
);
